// >>> hw/peak_hold_current_regulator.sv
// Peak and hold current regulation sequencer with fault protection and reporting.
// Assumes pins arrive asynchronously; configuration ports are static or on clk_i.
//
// What this block does
// - Phase input, directly or through the phase timer, picks peak or sustain level pair for the reference DAC.
// - Direct select set: phase input low gives peak, high gives sustain.
// - Direct select clear: mode follows internal timer dividing the phase input clock.
// - Peak duration set by three-bit prescale and eight-bit length.
// - Cycle runs while permit and cycle inputs are both high.
// - Cycle start resets timer and protection, loads peak or sustain upper level.
// - Cycle end drives gates low, resets timer, reports open load.
// - Peak phase uses peak levels, afterwards sustain levels.
// - Loop output low when current below selected reference, else high.
// - Below upper level: high-side on, freewheel off.
// - Above upper level: DAC to lower, high-side off, freewheel on.
// - Below lower level: DAC to upper, high-side on, freewheel off.
// - Protection latches release on rising edge of either control input.
// - Report bits and fault flag clear on serial select rising edge.
// - Open load reported only after falling edge of either control input.
// - Overvoltage without cutoff reported alongside priority faults, outputs and flag untouched.
// - Overvoltage with cutoff in cycle latches high-side off, freewheel on, flag.
// - Overcurrent always sets flag; inside a cycle latches both gates off.
// - First priority fault locks out later priority and open-load bits.
// - Open load when no loop state change during the whole cycle.
`include "phr_regs.svh"

module peak_hold_current_regulator
(
    // Clock, reset and clock enable
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Control pins
    input wire logic output_permit_input_i,
    input wire logic cycle_ctrl_i,
    input wire logic phase_in_i,
    input wire logic serial_select_low_i,
    // Comparator and fault detectors
    input wire logic current_above_i,
    input wire logic overcurrent_det_i,
    input wire logic overvolt_det_i,
    input wire logic hs_sat_det_i,
    input wire logic fw_sat_det_i,
    // Configuration
    input wire logic direct_phase_sel_i,
    input wire logic [`PHR_PRE_W-1:0] prescale_i,
    input wire logic [`PHR_LEN_W-1:0] phase_len_i,
    input wire logic overvolt_cutoff_i,
    input wire phr_pkg::level_t peak_upper_level_i,
    input wire phr_pkg::level_t peak_lower_level_i,
    input wire phr_pkg::level_t sustain_upper_level_i,
    input wire phr_pkg::level_t sustain_lower_level_i,
    // Drive and status outputs
    output logic hs_gate_o,
    output logic fw_gate_o,
    output phr_pkg::level_t dac_level_o,
    output logic loop_state_o,
    output logic peak_mode_o,
    output phr_pkg::report_t fault_report_o,
    // Open-drain fault pin: enable low pulls the pin low
    output logic fault_pin_o,
    output logic fault_pin_oe_b_o
);
    regulator_if rgi ();

    logic [`PHR_PIN_N-1:0] pin_meta_ff;
    logic [`PHR_PIN_N-1:0] pin_sync_ff;
    logic [`PHR_PIN_N-1:0] pin_prev_ff;
    logic [`PHR_PIN_N-1:0] pin_rise;
    logic permit_s;
    logic cycle_s;
    logic phase_s;
    logic above_s;
    logic cycle_on;
    logic cycle_on_ff;
    logic cycle_start;
    logic cycle_end;
    logic ctrl_rise;
    logic peak_mode;
    phr_pkg::loop_e loop_ff;
    phr_pkg::loop_e nxt_loop;
    logic changed_ff;
    logic prot_hs_off_ff;
    logic prot_fw_off_ff;
    logic prot_fw_on_ff;
    logic hs_gate_ff;
    logic fw_gate_ff;
    logic loop_state_ff;
    logic peak_mode_ff;
    phr_pkg::level_t dac_ff;
    phr_pkg::level_t nxt_dac;
    logic nxt_hs;
    logic nxt_fw;
    logic ovp_cut;
    logic sat_any;

    // Pick the reference level for a mode and a half of the hysteresis band
    function automatic phr_pkg::level_t pick_level
    (
        input logic peak,
        input logic lower,
        input phr_pkg::level_t pk_up,
        input phr_pkg::level_t pk_lo,
        input phr_pkg::level_t su_up,
        input phr_pkg::level_t su_lo
    );
        if (peak)
            pick_level = lower ? pk_lo : pk_up;
        else
            pick_level = lower ? su_lo : su_up;
    endfunction : pick_level

    // Three flip-flops per pin; edges look only at the second stage and its delay
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pin_meta_ff <= `PHR_RST_PINS;
            pin_sync_ff <= `PHR_RST_PINS;
            pin_prev_ff <= `PHR_RST_PINS;
        end
        else if (ce_i)
        begin
            pin_meta_ff[`PHR_PIN_PERMIT] <= output_permit_input_i;
            pin_meta_ff[`PHR_PIN_CYCLE] <= cycle_ctrl_i;
            pin_meta_ff[`PHR_PIN_PHASE] <= phase_in_i;
            pin_meta_ff[`PHR_PIN_SELECT] <= serial_select_low_i;
            pin_meta_ff[`PHR_PIN_ABOVE] <= current_above_i;
            pin_meta_ff[`PHR_PIN_OVERCURRENT] <= overcurrent_det_i;
            pin_meta_ff[`PHR_PIN_OVERVOLT] <= overvolt_det_i;
            pin_meta_ff[`PHR_PIN_HS_SAT] <= hs_sat_det_i;
            pin_meta_ff[`PHR_PIN_FW_SAT] <= fw_sat_det_i;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    assign pin_rise = pin_sync_ff & ~pin_prev_ff;
    assign permit_s = pin_sync_ff[`PHR_PIN_PERMIT];
    assign cycle_s = pin_sync_ff[`PHR_PIN_CYCLE];
    assign phase_s = pin_sync_ff[`PHR_PIN_PHASE];
    assign above_s = pin_sync_ff[`PHR_PIN_ABOVE];

    assign cycle_on = permit_s && cycle_s;
    assign cycle_start = cycle_on && !cycle_on_ff;
    assign cycle_end = !cycle_on && cycle_on_ff;
    assign ctrl_rise = pin_rise[`PHR_PIN_PERMIT] || pin_rise[`PHR_PIN_CYCLE];

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cycle_on_ff <= 1'b0;
        else if (ce_i)
            cycle_on_ff <= cycle_on;
    end

    // Timer is held loaded outside a cycle, so it is fresh at every start
    assign rgi.timer_load = !cycle_on;
    assign rgi.phase_edge = pin_rise[`PHR_PIN_PHASE];
    assign rgi.prescale = prescale_i;
    assign rgi.phase_len = phase_len_i;

    phase_timer u_phase_timer
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .tif(rgi.timer)
    );

    // Direct select: low level on the phase input means peak
    assign peak_mode = direct_phase_sel_i ? !phase_s : rgi.timer_running;

    always_comb
    begin
        nxt_loop = loop_ff;
        unique case (loop_ff)
            phr_pkg::LOOP_OFF:
            begin
                if (cycle_start)
                    nxt_loop = phr_pkg::LOOP_RISE;
            end
            phr_pkg::LOOP_RISE:
            begin
                if (!cycle_on)
                    nxt_loop = phr_pkg::LOOP_OFF;
                else if (above_s)
                    nxt_loop = phr_pkg::LOOP_FALL;
            end
            phr_pkg::LOOP_FALL:
            begin
                if (!cycle_on)
                    nxt_loop = phr_pkg::LOOP_OFF;
                else if (!above_s)
                    nxt_loop = phr_pkg::LOOP_RISE;
            end
            default:
                nxt_loop = phr_pkg::LOOP_OFF;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            loop_ff <= phr_pkg::LOOP_OFF;
        else if (ce_i)
            loop_ff <= nxt_loop;
    end

    // Any hysteresis turn inside a cycle proves the load is connected
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            changed_ff <= 1'b0;
        else if (ce_i)
        begin
            if (cycle_start)
                changed_ff <= 1'b0;
            else if (loop_ff != phr_pkg::LOOP_OFF && nxt_loop != loop_ff && cycle_on)
                changed_ff <= 1'b1;
        end
    end

    assign ovp_cut = pin_sync_ff[`PHR_PIN_OVERVOLT] && overvolt_cutoff_i;
    assign sat_any = pin_sync_ff[`PHR_PIN_HS_SAT] || pin_sync_ff[`PHR_PIN_FW_SAT];

    // Protection latches; a fault seen on the release edge still latches
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            prot_hs_off_ff <= 1'b0;
            prot_fw_off_ff <= 1'b0;
            prot_fw_on_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            prot_hs_off_ff <= (ctrl_rise ? 1'b0 : prot_hs_off_ff)
                || (cycle_on && (pin_sync_ff[`PHR_PIN_OVERCURRENT] || ovp_cut || sat_any));
            prot_fw_off_ff <= (ctrl_rise ? 1'b0 : prot_fw_off_ff)
                || (cycle_on && (pin_sync_ff[`PHR_PIN_OVERCURRENT] || sat_any));
            prot_fw_on_ff <= (ctrl_rise ? 1'b0 : prot_fw_on_ff)
                || (cycle_on && ovp_cut);
        end
    end

    // Gate drive; latched freewheel-off beats latched freewheel-on; a live overvoltage cutoff turns freewheel on unless overcurrent or saturation is live
    always_comb
    begin
        nxt_hs = cycle_on && (nxt_loop == phr_pkg::LOOP_RISE) && !prot_hs_off_ff;
        nxt_fw = cycle_on && !prot_fw_off_ff
            && ((nxt_loop == phr_pkg::LOOP_FALL) || prot_fw_on_ff);
        if (cycle_on && (pin_sync_ff[`PHR_PIN_OVERCURRENT] || sat_any))
        begin
            nxt_hs = 1'b0;
            nxt_fw = 1'b0;
        end
        else if (cycle_on && ovp_cut)
        begin
            nxt_hs = 1'b0;
            nxt_fw = 1'b1;
        end
        nxt_dac = pick_level(peak_mode, nxt_loop == phr_pkg::LOOP_FALL,
            peak_upper_level_i, peak_lower_level_i, sustain_upper_level_i, sustain_lower_level_i);
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            hs_gate_ff <= 1'b0;
            fw_gate_ff <= 1'b0;
            dac_ff <= `PHR_RST_LEVEL;
            loop_state_ff <= 1'b0;
            peak_mode_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            hs_gate_ff <= nxt_hs;
            fw_gate_ff <= nxt_fw;
            dac_ff <= nxt_dac;
            loop_state_ff <= above_s;
            peak_mode_ff <= peak_mode;
        end
    end

    // Fault reporting requests
    always_comb
    begin
        rgi.set_prio = `PHR_RST_REPORT;
        rgi.set_prio[`PHR_RPT_OVERCURRENT] = pin_sync_ff[`PHR_PIN_OVERCURRENT];
        rgi.set_prio[`PHR_RPT_FW_SAT] = cycle_on && pin_sync_ff[`PHR_PIN_FW_SAT];
        rgi.set_prio[`PHR_RPT_HS_SAT] = cycle_on && pin_sync_ff[`PHR_PIN_HS_SAT];
        rgi.set_prio[`PHR_RPT_OVERVOLT] = ovp_cut;
    end

    assign rgi.clear_report = pin_rise[`PHR_PIN_SELECT];
    assign rgi.set_ovp_info = pin_sync_ff[`PHR_PIN_OVERVOLT] && !overvolt_cutoff_i;
    assign rgi.set_open_load = cycle_end && !changed_ff;
    assign rgi.set_flag = pin_sync_ff[`PHR_PIN_OVERCURRENT] || ovp_cut
        || (cycle_on && sat_any);

    fault_reporter u_fault_reporter
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .rif(rgi.rpt)
    );

    assign hs_gate_o = hs_gate_ff;
    assign fw_gate_o = fw_gate_ff;
    assign dac_level_o = dac_ff;
    assign loop_state_o = loop_state_ff;
    assign peak_mode_o = peak_mode_ff;
    assign fault_report_o = rgi.report;
    // Pin only ever pulls low; the board pull-up gives the idle high
    assign fault_pin_o = 1'b0;
    assign fault_pin_oe_b_o = !rgi.flag;
endmodule : peak_hold_current_regulator

// >>> shared/phr_regs.svh
// Named constants of the peak and hold current regulator.
// Assumes inclusion by bare name from every file that needs a width or bit position.
`ifndef PHR_REGS_SVH
`define PHR_REGS_SVH

// Widths of the level, length, prescale and report fields
`define PHR_LEVEL_W 7
`define PHR_LEN_W 8
`define PHR_PRE_W 3
`define PHR_PRE_CNT_W 7
`define PHR_RPT_W 5

// Fault report bit positions
`define PHR_RPT_OVERCURRENT 0
`define PHR_RPT_OPEN_LOAD 1
`define PHR_RPT_FW_SAT 2
`define PHR_RPT_HS_SAT 3
`define PHR_RPT_OVERVOLT 4

// Positions of the asynchronous pins in the synchroniser vector
`define PHR_PIN_PERMIT 0
`define PHR_PIN_CYCLE 1
`define PHR_PIN_PHASE 2
`define PHR_PIN_SELECT 3
`define PHR_PIN_ABOVE 4
`define PHR_PIN_OVERCURRENT 5
`define PHR_PIN_OVERVOLT 6
`define PHR_PIN_HS_SAT 7
`define PHR_PIN_FW_SAT 8
`define PHR_PIN_N 9

// Reset values
`define PHR_RST_REPORT 5'h00
`define PHR_RST_LEVEL 7'h00
`define PHR_RST_LEN 8'h00
`define PHR_RST_PRE 7'h00
`define PHR_RST_PINS 9'h008

`endif

// >>> shared/phr_pkg.sv
// Types shared by the regulator modules.
// Assumes phr_regs.svh is on the include path.
`include "phr_regs.svh"

package phr_pkg;
    typedef logic [`PHR_LEVEL_W-1:0] level_t;
    typedef logic [`PHR_RPT_W-1:0] report_t;

    // Control loop state; OFF outside a regulation cycle
    typedef enum logic [1:0]
    {
        LOOP_OFF  = 2'h0,
        LOOP_RISE = 2'h1,
        LOOP_FALL = 2'h2
    } loop_e;
endpackage : phr_pkg

// >>> shared/regulator_if.sv
// Carrier between the regulator top and its phase timer and fault reporter.
// Assumes all three modules share one clock.
`include "phr_regs.svh"

interface regulator_if;
    logic timer_load;
    logic phase_edge;
    logic [`PHR_PRE_W-1:0] prescale;
    logic [`PHR_LEN_W-1:0] phase_len;
    logic timer_running;
    logic clear_report;
    phr_pkg::report_t set_prio;
    logic set_ovp_info;
    logic set_open_load;
    logic set_flag;
    phr_pkg::report_t report;
    logic flag;

    modport timer (input timer_load, phase_edge, prescale, phase_len, output timer_running);
    modport timer_ctl (output timer_load, phase_edge, prescale, phase_len, input timer_running);
    modport rpt (input clear_report, set_prio, set_ovp_info, set_open_load, set_flag,
                 output report, flag);
    modport rpt_ctl (output clear_report, set_prio, set_ovp_info, set_open_load, set_flag,
                     input report, flag);
endinterface : regulator_if

// >>> hw/phase_timer.sv
// Peak phase timer: prescaled count of phase clock edges.
// Assumes phase_edge is a synchronised one-cycle pulse on clk_i.
`include "phr_regs.svh"

module phase_timer
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Control
    regulator_if.timer tif
);
    logic [`PHR_PRE_CNT_W-1:0] pre_ff;
    logic [`PHR_LEN_W-1:0] len_ff;
    logic [`PHR_PRE_CNT_W-1:0] pre_mask;

    // Divisor is two to the power of the prescale field
    assign pre_mask = `PHR_PRE_CNT_W'((8'h01 << tif.prescale) - 8'h01);
    assign tif.timer_running = (len_ff != `PHR_RST_LEN);

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pre_ff <= `PHR_RST_PRE;
            len_ff <= `PHR_RST_LEN;
        end
        else if (ce_i)
        begin
            if (tif.timer_load)
            begin
                pre_ff <= `PHR_RST_PRE;
                len_ff <= tif.phase_len;
            end
            else if (tif.phase_edge && tif.timer_running)
            begin
                if (pre_ff == pre_mask)
                begin
                    pre_ff <= `PHR_RST_PRE;
                    len_ff <= len_ff - 8'h01;
                end
                else
                begin
                    pre_ff <= pre_ff + 7'h01;
                end
            end
        end
    end
endmodule : phase_timer

// >>> hw/fault_reporter.sv
// Fault report bits with first-fault priority lock and fault flag.
// Assumes set requests and clear are one-cycle pulses or levels on clk_i.
`include "phr_regs.svh"

module fault_reporter
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Requests and state
    regulator_if.rpt rif
);
    phr_pkg::report_t report_ff;
    phr_pkg::report_t nxt_report;
    phr_pkg::report_t new_prio;
    phr_pkg::report_t info;
    logic lock_ff;
    logic nxt_lock;
    logic flag_ff;
    logic nxt_flag;
    logic base_lock;

    assign rif.report = report_ff;
    assign rif.flag = flag_ff;

    // Set wins over the clear so a fault arriving with the select edge survives
    always_comb
    begin
        base_lock = rif.clear_report ? 1'b0 : lock_ff;
        new_prio = base_lock ? `PHR_RST_REPORT : rif.set_prio;
        info = `PHR_RST_REPORT;
        info[`PHR_RPT_OVERVOLT] = rif.set_ovp_info;
        info[`PHR_RPT_OPEN_LOAD] = rif.set_open_load && !base_lock && (new_prio == 5'h00);
        nxt_report = (rif.clear_report ? `PHR_RST_REPORT : report_ff) | new_prio | info;
        nxt_lock = base_lock | (new_prio != 5'h00);
        nxt_flag = (rif.clear_report ? 1'b0 : flag_ff) | rif.set_flag;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            report_ff <= `PHR_RST_REPORT;
            lock_ff <= 1'b0;
            flag_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            report_ff <= nxt_report;
            lock_ff <= nxt_lock;
            flag_ff <= nxt_flag;
        end
    end
endmodule : fault_reporter

// >>> testbench/regulator_sva.sv
// Checker of the regulator's port behaviour, bound to the top module.
// Assumes ce_i stays high while checked; sees only the top module's ports.
`include "phr_regs.svh"

module regulator_sva
(
    // Clock, reset and pins
    input wire logic clk_i, rst_b_i, ce_i,
    input wire logic output_permit_input_i, cycle_ctrl_i, phase_in_i, serial_select_low_i,
    input wire logic current_above_i, overcurrent_det_i, overvolt_det_i, hs_sat_det_i,
    input wire logic fw_sat_det_i, direct_phase_sel_i, overvolt_cutoff_i,
    // Levels
    input wire phr_pkg::level_t peak_upper_level_i, peak_lower_level_i,
    input wire phr_pkg::level_t sustain_upper_level_i, sustain_lower_level_i,
    // Outputs
    input wire logic hs_gate_o, fw_gate_o, loop_state_o, peak_mode_o, fault_pin_oe_b_o,
    input wire phr_pkg::level_t dac_level_o,
    input wire phr_pkg::report_t fault_report_o
);
    localparam int ON = 0, CM = 1, PH = 2, SL = 3, OC = 4, OV = 5, AN = 6;
    // Stage 1 is the synchronised view, stage 2 lines up with registered outputs
    logic [2:0][6:0] pp;
    logic [6:0] pins;
    logic flt;
    assign flt = overcurrent_det_i | overvolt_det_i | hs_sat_det_i | fw_sat_det_i;
    assign pins = {flt, overvolt_det_i, overcurrent_det_i, serial_select_low_i, phase_in_i,
                   current_above_i, output_permit_input_i & cycle_ctrl_i};
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            pp <= {3{7'h08}};
        else if (ce_i)
            pp <= {pp[1:0], pins};
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i || !ce_i);
    sequence sel_rise;
        pp[1][SL] && !pp[2][SL];
    endsequence
    sequence steady_cycle;
        pp[1][ON] && pp[2][ON] && fault_pin_oe_b_o;
    endsequence

    gates_idle_a: assert property (!pp[2][ON] |-> !hs_gate_o && !fw_gate_o)
        else $error("gate active outside a cycle");
    gates_excl_a: assert property (!(hs_gate_o && fw_gate_o))
        else $error("both gates on");
    loop_track_a: assert property (loop_state_o == pp[2][CM])
        else $error("loop state not following comparator");
    direct_mode_a: assert property (direct_phase_sel_i && pp[2][ON] |-> peak_mode_o == !pp[2][PH])
        else $error("direct phase mode wrong");
    upper_sel_a: assert property (hs_gate_o |->
        dac_level_o == (peak_mode_o ? peak_upper_level_i : sustain_upper_level_i))
        else $error("upper level not selected");
    lower_sel_a: assert property (fw_gate_o && fault_pin_oe_b_o |->
        dac_level_o == (peak_mode_o ? peak_lower_level_i : sustain_lower_level_i))
        else $error("lower level not selected");
    turn_down_a: assert property (steady_cycle ##0 hs_gate_o && pp[1][CM] |=>
        (fw_gate_o && !hs_gate_o) || !fault_pin_oe_b_o) else $error("no turn to freewheel");
    turn_up_a: assert property (steady_cycle ##0 fw_gate_o && !pp[1][CM] |=>
        (hs_gate_o && !fw_gate_o) || !fault_pin_oe_b_o) else $error("no turn to high side");
    clear_sel_a: assert property (sel_rise ##0 !pp[1][AN] && pp[1][ON] == pp[2][ON] |=>
        fault_report_o == 5'h00 && fault_pin_oe_b_o) else $error("report not cleared");
    ocp_flag_a: assert property (pp[1][OC] |=> !fault_pin_oe_b_o)
        else $error("overcurrent flag missing");
    ocp_gates_a: assert property (pp[1][OC] && pp[1][ON] |=> !hs_gate_o && !fw_gate_o)
        else $error("overcurrent gates not off");
    ovp_info_a: assert property (pp[1][OV] && !overvolt_cutoff_i |=>
        fault_report_o[`PHR_RPT_OVERVOLT]) else $error("overvoltage not reported");
    ovp_cut_a: assert property (pp[1][OV] && overvolt_cutoff_i &&
        pp[1][ON] && !pp[1][OC] |=> !hs_gate_o && fw_gate_o && !fault_pin_oe_b_o)
        else $error("overvoltage cutoff wrong");
endmodule : regulator_sva

bind peak_hold_current_regulator regulator_sva u_sva (.clk_i, .rst_b_i, .ce_i,
    .output_permit_input_i, .cycle_ctrl_i, .phase_in_i, .serial_select_low_i, .current_above_i,
    .overcurrent_det_i, .overvolt_det_i, .hs_sat_det_i, .fw_sat_det_i, .direct_phase_sel_i,
    .overvolt_cutoff_i, .peak_upper_level_i, .peak_lower_level_i, .sustain_upper_level_i,
    .sustain_lower_level_i, .hs_gate_o, .fw_gate_o, .loop_state_o, .peak_mode_o,
    .fault_pin_oe_b_o, .dac_level_o, .fault_report_o);

// >>> testbench/load_model.sv
// Solenoid load with sense comparator at the far side of the gate drives.
// Assumes one clock; current rises with the high-side drive and decays otherwise.
module load_model
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Drive, load state and reference
    input wire logic hs_gate_i,
    input wire logic open_i,
    input wire logic slow_i,
    input wire phr_pkg::level_t ref_i,
    // Comparator
    output logic above_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cur_ff;
    logic tick_ff;
    // Slow mode steps every other clock, like a high-inductance coil
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cur_ff <= 8'h00;
            tick_ff <= 1'b1;
        end
        else
        begin
            tick_ff <= slow_i ? !tick_ff : 1'b1;
            if (open_i)
                cur_ff <= 8'h00;
            else if (tick_ff && hs_gate_i && cur_ff != 8'hFF)
                cur_ff <= cur_ff + 8'h01;
            else if (tick_ff && !hs_gate_i && cur_ff != 8'h00)
                cur_ff <= cur_ff - 8'h01;
        end
    end
    assign above_o = cur_ff >= {1'b0, ref_i};
endmodule : load_model

// >>> testbench/peak_hold_current_regulator_bench.sv
// Self-checking bench of the regulator with a load model on the drives.
// Assumes the checker is bound by its own file; ce_i stays high.
module peak_hold_current_regulator_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_b_i, ce_i, permit, cycle, phase, sel, above, ov, direct, cutoff;
    logic open, slow, ph_run, hs, fw, loop, pk, fpin, oe_b;
    logic [2:0] det, prescale;
    logic [7:0] len;
    logic [1:0] phc;
    phr_pkg::level_t pu, pl, su, sl, dac;
    phr_pkg::report_t rpt;
    logic [4:0] bitv [3];
    int n_fail, compares, cyc, turns;

    peak_hold_current_regulator u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .output_permit_input_i(permit), .cycle_ctrl_i(cycle), .phase_in_i(phase),
        .serial_select_low_i(sel), .current_above_i(above), .overcurrent_det_i(det[0]),
        .overvolt_det_i(ov), .hs_sat_det_i(det[2]), .fw_sat_det_i(det[1]),
        .direct_phase_sel_i(direct), .prescale_i(prescale), .phase_len_i(len),
        .overvolt_cutoff_i(cutoff), .peak_upper_level_i(pu), .peak_lower_level_i(pl),
        .sustain_upper_level_i(su), .sustain_lower_level_i(sl), .hs_gate_o(hs), .fw_gate_o(fw),
        .dac_level_o(dac), .loop_state_o(loop), .peak_mode_o(pk), .fault_report_o(rpt),
        .fault_pin_o(fpin), .fault_pin_oe_b_o(oe_b));
    load_model u_load (.clk_i(clk_i), .rst_b_i(rst_b_i), .hs_gate_i(hs), .open_i(open),
        .slow_i(slow), .ref_i(dac), .above_o(above));

    always #25 clk_i = !clk_i;
    always @(posedge fw) turns++;
    // Phase clock for the timer: one rising edge every 8 clocks
    always @(negedge clk_i)
    begin
        if (ph_run)
        begin
            phc <= phc + 2'h1;
            if (phc == 2'h3)
                phase <= !phase;
        end
    end
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            n_fail++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tk
    task automatic start();
        permit = 1'b1;
        cycle = 1'b1;
        tk(4);
    endtask : start
    // Long idle lets the coil current decay before the next cycle
    task automatic stop_cyc();
        cycle = 1'b0;
        tk(60);
    endtask : stop_cyc
    task automatic sel_pulse();
        sel = 1'b0;
        tk(4);
        sel = 1'b1;
        tk(5);
    endtask : sel_pulse
    task automatic stop_test();
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    initial
    begin
        clk_i = 1'b0; rst_b_i = 1'b0; ce_i = 1'b1; permit = 1'b0; cycle = 1'b0;
        phase = 1'b0; sel = 1'b1; det = 3'h0; ov = 1'b0; direct = 1'b1; cutoff = 1'b0;
        prescale = 3'h1; len = 8'h03; open = 1'b0; slow = 1'b0; ph_run = 1'b0; phc = 2'h0;
        pu = 7'h28; pl = 7'h20; su = 7'h14; sl = 7'h0E;
        bitv = '{5'h01, 5'h04, 5'h08};
        n_fail = 0; compares = 0; cyc = 0; turns = 0;
        tk(12);
        rst_b_i = 1'b1;
        tk(2);
        chk("outputs", 8'h03, {2'h0, fpin, hs, fw, loop, pk, oe_b});
        chk("report", 8'h00, {3'h0, rpt});
        start();
        chk("dac", {1'b0, pu}, {1'b0, dac});
        chk("drive", 8'h06, {5'h0, pk, hs, fw});
        tk(150);
        chk("turned", 8'h01, {7'h0, turns != 0});
        phase = 1'b1;
        tk(4);
        chk("mode", 8'h00, {7'h0, pk});
        tk(100);
        chk("hold dac", 8'h01, {7'h0, dac == su || dac == sl});
        stop_cyc();
        chk("end", 8'h00, {1'b0, hs, fw, rpt});
        direct = 1'b0;
        slow = 1'b1;
        ph_run = 1'b1;
        start();
        tk(26);
        chk("peak early", 8'h01, {7'h0, pk});
        tk(50);
        chk("peak over", 8'h00, {7'h0, pk});
        stop_cyc();
        ph_run = 1'b0;
        slow = 1'b0;
        len = 8'h00;
        start();
        chk("no peak", {1'b0, su}, {1'b0, dac});
        stop_cyc();
        chk("short cycle", 8'h22, {2'h0, oe_b, rpt});
        sel_pulse();
        open = 1'b1;
        start();
        tk(30);
        chk("open early", 8'h20, {2'h0, oe_b, rpt});
        stop_cyc();
        chk("open load", 8'h22, {2'h0, oe_b, rpt});
        sel_pulse();
        chk("cleared", 8'h20, {2'h0, oe_b, rpt});
        open = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            start();
            tk(16);
            det[i] = 1'b1;
            tk(2);
            det = 3'h0;
            det[(i + 1) % 3] = 1'b1;
            ov = 1'b1;
            tk(2);
            det = 3'h0;
            ov = 1'b0;
            tk(4);
            chk("priority", {3'h0, bitv[i] | 5'h10}, {3'h0, rpt});
            chk("latched", 8'h00, {5'h0, hs, fw, oe_b});
            cycle = 1'b0;
            tk(4);
            cycle = 1'b1;
            tk(4);
            chk("released", 8'h04, {5'h0, hs, fw, oe_b});
            stop_cyc();
            sel_pulse();
            chk("clear", 8'h20, {2'h0, oe_b, rpt});
        end
        cutoff = 1'b1;
        start();
        tk(16);
        ov = 1'b1;
        tk(2);
        ov = 1'b0;
        tk(4);
        chk("ovp report", 8'h10, {3'h0, rpt});
        chk("ovp drive", 8'h02, {5'h0, hs, fw, oe_b});
        stop_cyc();
        stop_test();
    end
endmodule : peak_hold_current_regulator_bench
